// ---- hw/reset_source_sequencer.sv ----
// Purpose: gathers reset sources and sequences the core reset
// Assumes: rst marks power-up; RC oscillator slower than ref_clk / 4
// Notes:   APB slave, zero wait states, sticky events with mask
`timescale 1ns/1ps
module reset_source_sequencer #(
    parameter int DELAY_PULSES = reset_seq_pkg::DELAY_RC_PULSES
) (
    input  wire logic                           ref_clk,
    input  wire logic                           rst,
    input  wire logic                           master_reset_pin_n,
    input  wire logic                           brownout_in,
    input  wire logic                           rc_osc_running,
    input  wire logic                           rc_osc_clk,
    input  wire logic                           watchdog_overflow,
    input  wire logic                           wakeup_event,
    input  wire logic [7:0]                     wakeup_pins,
    output logic                                core_reset_n,
    output logic                                restart_pulse,
    output logic [reset_seq_pkg::PC_W-1:0]      reset_vector,
    output logic                                irq,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [31:0]                    paddr,
    input  wire logic [31:0]                    pwdata,
    output logic [31:0]                         prdata,
    output logic                                pready,
    output logic                                pslverr
);
    logic [1:0]                 pin_sync;
    logic [1:0]                 bor_sync;
    logic [1:0]                 rc_run_sync;
    logic [2:0]                 rc_clk_sync;
    logic                       pin_prev;
    logic                       bor_prev;
    logic                       power_latch;
    logic                       wake_hold;
    logic                       dog_hold;
    logic                       hold;
    logic                       core_reset_seen;
    logic                       bor_enabled;
    logic                       bor_active;
    logic [2:0]                 config_reg;
    logic [reset_seq_pkg::EV_W-1:0] status;
    logic [reset_seq_pkg::EV_W-1:0] mask;
    logic [reset_seq_pkg::EV_W-1:0] events;
    logic [7:0]                 wakeup_pending_flags;
    logic                       wr_en;
    logic                       setup;
    logic [reset_seq_pkg::ADDR_W-1:0] addr;
    logic [31:0]                next_rdata;
    logic                       next_err;

    delay_if dly ();

    power_up_delay_counter #(
        .LIMIT (DELAY_PULSES)
    ) u_delay (
        .ref_clk (ref_clk),
        .rst     (rst),
        .dly     (dly)
    );

    // Pins cross in through two flops and the second is looked at; the RC clock adds a third for edge detection
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_sync    <= 2'h0;
            bor_sync    <= 2'h0;
            rc_run_sync <= 2'h0;
            rc_clk_sync <= 3'h0;
        end else begin
            pin_sync    <= {pin_sync[0], master_reset_pin_n};
            bor_sync    <= {bor_sync[0], brownout_in};
            rc_run_sync <= {rc_run_sync[0], rc_osc_running};
            rc_clk_sync <= {rc_clk_sync[1:0], rc_osc_clk};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_prev <= 1'b0;
            bor_prev <= 1'b0;
        end else begin
            pin_prev <= pin_sync[1];
            bor_prev <= bor_active;
        end
    end

    assign bor_enabled = !(config_reg[reset_seq_pkg::CFG_BROWNOUT_CFG_BIT0]
                           && config_reg[reset_seq_pkg::CFG_BROWNOUT_CFG_BIT1]);
    assign bor_active  = bor_enabled && bor_sync[1];

    // The power-up latch drives the delay counter, gated by RC oscillator running and pin high
    assign dly.run  = power_latch && rc_run_sync[1] && pin_sync[1];
    assign dly.tick = rc_clk_sync[1] && !rc_clk_sync[2];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_latch <= 1'b1;
        end else if (dly.done) begin
            power_latch <= 1'b0;
        end
    end

    // Wakeup and watchdog are one-cycle events, stretched to a single reset cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wake_hold <= 1'b0;
            dog_hold  <= 1'b0;
        end else begin
            wake_hold <= wakeup_event;
            dog_hold  <= watchdog_overflow && config_reg[reset_seq_pkg::CFG_WDT_EN];
        end
    end

    assign hold = power_latch || !pin_sync[1] || bor_active
                  || wake_hold || dog_hold;

    // Released and asserted only on a clock edge, one cycle after hold changes
    // Restart pulse lags the release by one cycle so the core sees it out of reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            core_reset_n    <= 1'b0;
            core_reset_seen <= 1'b0;
            restart_pulse   <= 1'b0;
            reset_vector    <= reset_seq_pkg::RESET_VECTOR;
        end else begin
            core_reset_n    <= !hold;
            core_reset_seen <= core_reset_n;
            restart_pulse   <= core_reset_n && !core_reset_seen;
            reset_vector    <= reset_seq_pkg::RESET_VECTOR;
        end
    end

    // Pending flags keep their value across core resets; power-up and each wakeup event load them
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wakeup_pending_flags <= reset_seq_pkg::WAKE_PEND_RESET;
        end else if (wakeup_event) begin
            wakeup_pending_flags <= wakeup_pins;
        end else if (wr_en && addr == reset_seq_pkg::OFF_WAKE_PEND) begin
            wakeup_pending_flags <= wakeup_pending_flags & ~pwdata[7:0];
        end
    end

    always_comb begin
        events = '0;
        events[reset_seq_pkg::EV_WAKEUP]   = wakeup_event;
        events[reset_seq_pkg::EV_BROWNOUT] = bor_active && !bor_prev;
        events[reset_seq_pkg::EV_WATCHDOG] = watchdog_overflow
                                             && config_reg[reset_seq_pkg::CFG_WDT_EN];
        events[reset_seq_pkg::EV_PIN]      = pin_prev && !pin_sync[1];
    end

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign addr  = paddr[reset_seq_pkg::ADDR_W-1:0];

    // Set wins over a same-cycle clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status <= reset_seq_pkg::STATUS_RESET;
        end else if (wr_en && addr == reset_seq_pkg::OFF_STATUS) begin
            status <= (status & ~pwdata[reset_seq_pkg::EV_W-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mask       <= reset_seq_pkg::MASK_RESET;
            config_reg <= reset_seq_pkg::CONFIG_RESET;
        end else if (wr_en && addr == reset_seq_pkg::OFF_MASK) begin
            mask <= pwdata[reset_seq_pkg::EV_W-1:0];
        end else if (wr_en && addr == reset_seq_pkg::OFF_CONFIG) begin
            config_reg <= pwdata[2:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (addr)
            reset_seq_pkg::OFF_STATUS:    next_rdata[reset_seq_pkg::EV_W-1:0] = status;
            reset_seq_pkg::OFF_MASK:      next_rdata[reset_seq_pkg::EV_W-1:0] = mask;
            reset_seq_pkg::OFF_CONFIG:    next_rdata[2:0] = config_reg;
            reset_seq_pkg::OFF_WAKE_PEND: next_rdata[7:0] = wakeup_pending_flags;
            reset_seq_pkg::OFF_STATE:     next_rdata[3:0] = {bor_active, dly.run,
                                                             power_latch, core_reset_n};
            default:                      next_err = 1'b1;
        endcase
        if (paddr[31:reset_seq_pkg::ADDR_W] != '0 || paddr[1:0] != 2'h0) begin
            next_err = 1'b1;
        end
    end

    // Zero wait states: ready rises in the first access cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && next_err;
            if (setup) begin
                prdata <= next_err ? 32'h0000_0000 : next_rdata;
            end
        end
    end
endmodule

// ---- hw/reset_seq_pkg.sv ----
// Purpose: shared constants for the reset source sequencer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   event bit positions are shared by status and mask
package reset_seq_pkg;
    localparam int         ADDR_W         = 5;
    localparam logic [4:0] OFF_STATUS     = 5'h00;
    localparam logic [4:0] OFF_MASK       = 5'h04;
    localparam logic [4:0] OFF_CONFIG     = 5'h08;
    localparam logic [4:0] OFF_WAKE_PEND  = 5'h0C;
    localparam logic [4:0] OFF_STATE      = 5'h10;

    localparam int EV_W        = 5;
    localparam int EV_POWER_ON = 0;
    localparam int EV_WAKEUP   = 1;
    localparam int EV_BROWNOUT = 2;
    localparam int EV_WATCHDOG = 3;
    localparam int EV_PIN      = 4;

    localparam int CFG_BROWNOUT_CFG_BIT0    = 0;
    localparam int CFG_BROWNOUT_CFG_BIT1    = 1;
    localparam int CFG_WDT_EN  = 2;
    localparam logic [2:0] CONFIG_RESET    = 3'h4;
    localparam logic [4:0] STATUS_RESET    = 5'h01;
    localparam logic [4:0] MASK_RESET      = 5'h00;
    localparam logic [7:0] WAKE_PEND_RESET = 8'hFF;

    localparam int PC_W = 11;
    localparam logic [10:0] RESET_VECTOR = 11'h7FF;

    localparam int DELAY_W          = 24;
    localparam int DELAY_MS         = 72;
    localparam int RC_OSC_HZ        = 1000000;
    localparam int DELAY_RC_PULSES  = DELAY_MS * (RC_OSC_HZ / 1000);
endpackage

// ---- hw/delay_if.sv ----
// Purpose: links the sequencer to its start-up delay counter
// Assumes: all signals on ref_clk
// Notes:   tick is a one-cycle pulse per RC oscillator period
`timescale 1ns/1ps
interface delay_if;
    logic run;
    logic tick;
    logic done;
    modport ctrl  (output run, output tick, input done);
    modport timer (input run, input tick, output done);
endinterface

// ---- hw/power_up_delay_counter.sv ----
// Purpose: counts RC oscillator pulses for the power-up delay
// Assumes: tick already synchronised and edge detected
// Notes:   dropping run restarts the count from zero
`timescale 1ns/1ps
module power_up_delay_counter #(
    parameter int LIMIT = reset_seq_pkg::DELAY_RC_PULSES
) (
    input  wire logic   ref_clk,
    input  wire logic   rst,
    delay_if.timer      dly
);
    localparam logic [reset_seq_pkg::DELAY_W-1:0] LAST =
        reset_seq_pkg::DELAY_W'(LIMIT - 1);

    logic [reset_seq_pkg::DELAY_W-1:0] count;

    always_ff @(posedge ref_clk) begin
        if (rst || !dly.run) begin
            count    <= '0;
            dly.done <= 1'b0;
        end else if (dly.tick && !dly.done) begin
            count <= count + 1'b1;
            if (count == LAST) begin
                dly.done <= 1'b1;
            end
        end
    end
endmodule

// ---- dv/reset_board_model.sv ----
// Purpose: board side of the sequencer: reset pin, supply monitor, RC oscillator
// Assumes: bench requests change just after ref_clk edges
// Notes:   RC clock is ref_clk / 8, inside the ref_clk / 4 limit
`timescale 1ns/1ps
module reset_board_model (
    input  wire logic ref_clk,
    input  wire logic pin_low_req,
    input  wire logic brown_req,
    output logic      master_reset_pin_n,
    output logic      brownout_in,
    output logic      rc_osc_running,
    output logic      rc_osc_clk
);
    logic [2:0] div;
    initial begin
        div = 3'h0;
        master_reset_pin_n = 1'b0;
        brownout_in = 1'b0;
        rc_osc_running = 1'b1;
        rc_osc_clk = 1'b0;
    end
    always @(posedge ref_clk) begin
        div <= div + 3'h1;
        rc_osc_clk <= div[2];
        master_reset_pin_n <= !pin_low_req;
        brownout_in <= brown_req;
    end
endmodule

// ---- dv/reset_seq_assertions.sv ----
// Purpose: port checks for the reset source sequencer
// Assumes: one clock domain, rst active high
// Notes:   gated sources need the config, so the bench judges those
`timescale 1ns/1ps
module reset_seq_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        master_reset_pin_n,
    input wire logic        wakeup_event,
    input wire logic        core_reset_n,
    input wire logic        restart_pulse,
    input wire logic [10:0] reset_vector,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_vector_top: assert property (reset_vector == reset_seq_pkg::RESET_VECTOR)
        else $error("reset vector off");
    a_pin_holds: assert property ((!master_reset_pin_n)[*3] |=> !core_reset_n)
        else $error("pin low without core reset");
    a_wake_resets: assert property (wakeup_event |-> ##[1:3] !core_reset_n)
        else $error("wakeup without core reset");
    a_restart_follows: assert property ($rose(core_reset_n) |=> restart_pulse)
        else $error("no restart pulse");
    a_restart_cause: assert property (restart_pulse |-> core_reset_n && !$past(core_reset_n, 2))
        else $error("restart pulse without release");
    a_restart_single: assert property (restart_pulse |=> !restart_pulse)
        else $error("restart pulse too long");
    a_apb_ready: assert property (psel && !penable |=> pready && penable)
        else $error("no ready in access");
    a_apb_refuse: assert property (psel && !penable && (paddr > 32'h10 || paddr[1:0] != 2'h0)
        |=> pslverr)
        else $error("bad address accepted");
    c_restart: cover property (restart_pulse);
    c_refused: cover property (pslverr);
    c_irq: cover property (irq);
endmodule

bind reset_source_sequencer reset_seq_checker chk_u (.ref_clk, .rst, .master_reset_pin_n,
    .wakeup_event, .core_reset_n, .restart_pulse, .reset_vector, .psel, .penable, .paddr,
    .pready, .pslverr, .irq);

// ---- dv/reset_source_sequencer_tb.sv ----
// Purpose: self-checking bench for the reset source sequencer
// Assumes: delay shortened to 4 RC pulses
// Notes:   APB results go through a queue to a monitor process
`timescale 1ns/1ps
module reset_source_sequencer_tb;
    logic        ref_clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pin_low_req = 1'b1, brown_req = 1'b0, watchdog_overflow = 1'b0;
    logic        wakeup_event = 1'b0, core_reset_n, restart_pulse, irq, pready, pslverr;
    logic        master_reset_pin_n, brownout_in, rc_osc_running, rc_osc_clk;
    logic [7:0]  wakeup_pins = 8'h00;
    logic [10:0] reset_vector;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, seed;
    logic [33:0] expq[$];
    logic [33:0] e;
    int          miscompares = 0, samples_checked = 0, n;

    reset_source_sequencer #(.DELAY_PULSES(4)) dut_u (.ref_clk, .rst, .master_reset_pin_n,
        .brownout_in, .rc_osc_running, .rc_osc_clk, .watchdog_overflow, .wakeup_event,
        .wakeup_pins, .core_reset_n, .restart_pulse, .reset_vector, .irq, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    reset_board_model board_u (.ref_clk, .pin_low_req, .brown_req, .master_reset_pin_n,
        .brownout_in, .rc_osc_running, .rc_osc_clk);

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic compare_val(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Counts: %0d compared, %0d miscompares", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wait_core(input int bound);
        n = 0;
        while (core_reset_n !== 1'b1 && n < bound) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= bound) begin
            miscompares++;
            complete_run();
        end
    endtask
    // Request held until pready is seen high, then released
    task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       input logic e_err, input logic [31:0] e_dat);
        expq.push_back({wr, e_err, e_dat});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {27'h0, a};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Enabled short pulses must give one low cycle, enabled held levels a long one, disabled sources none, no delay after
    task automatic src_test(input int kind, input logic hit);
        int lows;
        lows = 0;
        wakeup_event <= (kind == 0);
        watchdog_overflow <= (kind == 1);
        pin_low_req <= (kind == 2);
        brown_req <= (kind == 3);
        repeat (10) begin
            @(posedge ref_clk);
            wakeup_event <= 1'b0;
            watchdog_overflow <= 1'b0;
            lows += (core_reset_n === 1'b0);
        end
        pin_low_req <= 1'b0;
        brown_req <= 1'b0;
        wait_core(8);
        compare_val({31'h0, lows == 0, kind < 2 ? lows == 1 : lows > 4}, {31'h0, !hit, hit});
        repeat (4) @(posedge ref_clk);
        $display("source %0d test done", kind);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (6000) @(posedge ref_clk);
        miscompares++;
        complete_run();
    end
    always @(posedge ref_clk) begin
        if ((psel & penable & pready) === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            compare_val({pslverr, e[33] ? 32'h0 : prdata}, {e[32], e[33] ? 32'h0 : e[31:0]});
        end
    end
    initial begin
        seed = 32'h5CDFCE02;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (10) @(posedge ref_clk);
        compare_val({32'h0, core_reset_n}, 33'h0);
        pin_low_req <= 1'b0;
        repeat (20) @(posedge ref_clk);
        compare_val({32'h0, core_reset_n}, 33'h0);
        wait_core(60);
        compare_val({22'h0, reset_vector}, {22'h0, reset_seq_pkg::RESET_VECTOR});
        $display("power-on test done");
        apb(0, reset_seq_pkg::OFF_STATUS, 32'h0, 1'b0, {27'h0, reset_seq_pkg::STATUS_RESET});
        apb(0, reset_seq_pkg::OFF_MASK, 32'h0, 1'b0, {27'h0, reset_seq_pkg::MASK_RESET});
        apb(0, reset_seq_pkg::OFF_CONFIG, 32'h0, 1'b0, {29'h0, reset_seq_pkg::CONFIG_RESET});
        apb(0, reset_seq_pkg::OFF_WAKE_PEND, 32'h0, 1'b0, {24'h0, reset_seq_pkg::WAKE_PEND_RESET});
        apb(0, 5'h14, 32'h0, 1'b1, 32'h0);
        apb(1, 5'h02, 32'hFF, 1'b1, 32'h0);
        compare_val({32'h0, irq}, 33'h0);
        apb(1, reset_seq_pkg::OFF_MASK, 32'h1F, 1'b0, 32'h0);
        @(posedge ref_clk);
        compare_val({32'h0, irq}, 33'h1);
        apb(1, reset_seq_pkg::OFF_STATUS, 32'h1F, 1'b0, 32'h0);
        apb(1, reset_seq_pkg::OFF_WAKE_PEND, 32'hFF, 1'b0, 32'h0);
        compare_val({32'h0, irq}, 33'h0);
        $display("register test done");
        void'(xorshift());
        wakeup_pins <= seed[7:0];
        src_test(0, 1'b1);
        apb(0, reset_seq_pkg::OFF_WAKE_PEND, 32'h0, 1'b0, {24'h0, wakeup_pins});
        apb(0, reset_seq_pkg::OFF_STATUS, 32'h0, 1'b0, 32'h2);
        compare_val({32'h0, irq}, 33'h1);
        apb(1, reset_seq_pkg::OFF_CONFIG, 32'h3, 1'b0, 32'h0);
        src_test(3, 1'b0);
        src_test(1, 1'b0);
        apb(1, reset_seq_pkg::OFF_CONFIG, 32'h4, 1'b0, 32'h0);
        for (int k = 1; k < 4; k++)
            src_test(k, 1'b1);
        complete_run();
    end
endmodule
